// file: rtl/dlo_overlay_renderer.sv
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps

// What this block does
// - Hires bit honoured only with graphics on
// - Hires byte: upper nibble left, lower right
// - Lores bit honoured only with graphics on
// - End bit: finish record, await vsync, restart
// - Fetch only flagged optional data, fixed order
// - At most twenty extra bytes per record
// - Resolution bits select standard, high, low
// - Text ignores resolution; text plus graphics off
// - Standard: one byte per pixel, zero transparent
// - Add step to screen address each graphics line, each eighth text line
// - Lores widths 128/160/168, else like standard
// - Hires widths 512/640/672, zero nibble transparent
// - Text 64/80/84 chars, char then attribute
// - Char code picks glyph from font base
// - Attribute bit7 clear: background transparent or 128
// - Attribute bit7 set: background opaque, plus 128
// - No-transparency from control bit 2
// - Two bytes per char, one extra when scrolled
module dlo_overlay_renderer #(
  parameter int MEM_ADDR_W = 24
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic VSYNC,
  input wire logic LINE_START,
  output logic MEM_REQ,
  output logic [23:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [7:0] MEM_DATA,
  output logic PIX_VALID,
  output logic [7:0] PIX_INDEX,
  output logic PIX_TRANSP,
  output logic LINE_DONE
);

  if (MEM_ADDR_W != dlo_pkg::ADDR_W) begin : g_chk
    $error("MEM_ADDR_W must equal the package address width");
  end

  dlo_pkg::dlo_st_t s;
  dlo_pkg::dlo_st_t next_s;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic dlo_pkg::dlo_mode_t mode_of(input logic [15:0] cw);
    dlo_pkg::dlo_mode_t m;
    m = dlo_pkg::M_OFF;
    if (cw[dlo_pkg::CW_OVL_OFF]) begin
      m = dlo_pkg::M_OFF;
    end else if (cw[dlo_pkg::CW_TXT_ON] && cw[dlo_pkg::CW_GFX_ON]) begin
      m = dlo_pkg::M_OFF;
    end else if (cw[dlo_pkg::CW_TXT_ON]) begin
      m = dlo_pkg::M_TEXT;
    end else if (cw[dlo_pkg::CW_GFX_ON]) begin
      // Forbidden combination shown as overlay off, the safest picture
      case ({cw[dlo_pkg::CW_HIRES], cw[dlo_pkg::CW_LORES]})
        2'b00: m = dlo_pkg::M_SR;
        2'b10: m = dlo_pkg::M_HR;
        2'b01: m = dlo_pkg::M_LR;
        default: m = dlo_pkg::M_OFF;
      endcase
    end
    return m;
  endfunction

  function automatic logic [9:0] line_items(input dlo_pkg::dlo_mode_t m,
                                            input logic [1:0] w);
    logic [1:0] k;
    k = (w > 2'h2) ? dlo_pkg::WIDTH_NORMAL : w;
    case (m)
      dlo_pkg::M_SR: return dlo_pkg::SR_PIX[k];
      dlo_pkg::M_LR: return dlo_pkg::LR_PIX[k];
      dlo_pkg::M_HR: return dlo_pkg::HR_PIX[k];
      dlo_pkg::M_TEXT: return dlo_pkg::TX_CHR[k];
      default: return 10'h000;
    endcase
  endfunction

  // Returns {transparent, colour index} for the pixel at the shifter head
  function automatic logic [8:0] pix_of(input dlo_pkg::dlo_mode_t m, input logic [7:0] sh,
                                        input logic [7:0] attr, input logic no_trans);
    logic [8:0] r;
    r = 9'h000;
    case (m)
      dlo_pkg::M_HR: r = {(sh[7:4] == 4'h0) && !no_trans, 4'h0, sh[7:4]};
      dlo_pkg::M_TEXT: begin
        if (sh[7]) begin
          r = {1'b0, 1'b0, attr[6:0]};
        end else if (attr[7]) begin
          r = {1'b0, 1'b1, attr[6:0]};
        end else begin
          r = {!no_trans, dlo_pkg::TXT_BG_SOLID};
        end
      end
      default: r = {(sh == 8'h00) && !no_trans, sh};
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic vs_edge;
    logic ls_edge;
    logic got;
    logic want;
    logic [23:0] faddr;
    logic [8:0] px;
    logic last;
    vs_edge = s.vs_s && !s.vs_d;
    ls_edge = s.ls_s && !s.ls_d;
    got = s.mem.req && MEM_ACK;
    want = 1'b0;
    faddr = s.list_ptr;
    px = pix_of(s.mode, s.sh, s.attr, s.no_trans);
    last = 1'b0;
    next_s = s;
    next_s.pix.valid = 1'b0;
    next_s.pix.line_done = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.vs_m = VSYNC;
    next_s.vs_s = s.vs_m;
    next_s.vs_d = s.vs_s;
    next_s.ls_m = LINE_START;
    next_s.ls_s = s.ls_m;
    next_s.ls_d = s.ls_s;

    // APB slave: one wait state, then answer
    if (PSEL && PENABLE && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      case (PADDR)
        dlo_pkg::OFS_CTRL: begin
          next_s.prdata[dlo_pkg::CTRL_ENABLE_BIT] = s.en;
          next_s.prdata[dlo_pkg::CTRL_NO_TRANS_BIT] = s.no_trans;
        end
        dlo_pkg::OFS_LIST: next_s.prdata[23:0] = s.list_base;
        dlo_pkg::OFS_STATUS: begin
          next_s.prdata[dlo_pkg::STAT_STATE_LSB +: 4] = s.state;
          next_s.prdata[dlo_pkg::STAT_MODE_LSB +: 3] = s.mode;
          next_s.prdata[dlo_pkg::STAT_LINES_LSB +: 8] = s.line_left;
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (PSEL && PENABLE && s.pready && PWRITE) begin
      case (PADDR)
        dlo_pkg::OFS_CTRL: begin
          next_s.en = PWDATA[dlo_pkg::CTRL_ENABLE_BIT];
          next_s.no_trans = PWDATA[dlo_pkg::CTRL_NO_TRANS_BIT];
        end
        dlo_pkg::OFS_LIST: next_s.list_base = PWDATA[23:0];
        default: next_s.list_base = s.list_base;
      endcase
    end

    // Display list engine
    case (s.state)
      dlo_pkg::S_WAIT_VS: begin
        if (s.en && vs_edge) begin
          next_s.list_ptr = s.list_base;
          next_s.width = dlo_pkg::WIDTH_NORMAL;
          next_s.row = 3'h0;
          next_s.state = dlo_pkg::S_CW_LO;
        end
      end
      dlo_pkg::S_CW_LO: begin
        want = 1'b1;
        if (got) begin
          next_s.cw[7:0] = MEM_DATA;
          next_s.list_ptr = s.list_ptr + 24'h00_0001;
          next_s.state = dlo_pkg::S_CW_HI;
        end
      end
      dlo_pkg::S_CW_HI: begin
        want = 1'b1;
        if (got) begin
          next_s.cw[15:8] = MEM_DATA;
          next_s.list_ptr = s.list_ptr + 24'h00_0001;
          next_s.grp = 3'h0;
          next_s.gbyte = 3'h0;
          next_s.extra = 5'h00;
          next_s.rpt = 8'h00;
          next_s.state = dlo_pkg::S_OPT;
        end
      end
      dlo_pkg::S_OPT: begin
        if (s.grp == dlo_pkg::GRP_DONE) begin
          next_s.line_left = s.rpt;
          next_s.mode = mode_of(s.cw);
          next_s.state = dlo_pkg::S_WAIT_LINE;
        end else if (!s.cw[dlo_pkg::CW_GRP0 + 32'(s.grp)]) begin
          next_s.grp = s.grp + 3'h1;
        end else begin
          want = 1'b1;
          if (got) begin
            next_s.list_ptr = s.list_ptr + 24'h00_0001;
            next_s.extra = s.extra + 5'h01;
            if (s.gbyte == dlo_pkg::GRP_LEN[s.grp] - 3'h1) begin
              next_s.gbyte = 3'h0;
              next_s.grp = s.grp + 3'h1;
            end else begin
              next_s.gbyte = s.gbyte + 3'h1;
            end
            // Map groups are read past; their consumer is not in this block
            case (s.grp)
              dlo_pkg::GRP_RPT: next_s.rpt = MEM_DATA;
              dlo_pkg::GRP_OVADR: begin
                case (s.gbyte)
                  3'h0: next_s.scr_base[7:0] = MEM_DATA;
                  3'h1: next_s.scr_base[15:8] = MEM_DATA;
                  3'h2: next_s.scr_base[23:16] = MEM_DATA;
                  3'h3: next_s.step[7:0] = MEM_DATA;
                  default: next_s.step[11:8] = MEM_DATA[3:0];
                endcase
                next_s.row = 3'h0;
              end
              dlo_pkg::GRP_SCRL: begin
                if (s.gbyte == 3'h0) begin
                  next_s.hscroll = MEM_DATA;
                end
              end
              dlo_pkg::GRP_FONT: next_s.font = MEM_DATA;
              dlo_pkg::GRP_ATT: begin
                if (s.gbyte == 3'h0) begin
                  next_s.width = MEM_DATA[1:0];
                end
              end
              default: next_s.font = s.font;
            endcase
          end
        end
      end
      dlo_pkg::S_WAIT_LINE: begin
        if (ls_edge) begin
          next_s.fptr = s.scr_base;
          next_s.items = line_items(s.mode, s.width);
          next_s.skip = (s.hscroll != 8'h00);
          case (s.mode)
            dlo_pkg::M_OFF: next_s.state = dlo_pkg::S_LINE_END;
            dlo_pkg::M_TEXT: next_s.state = dlo_pkg::S_TX_CHAR;
            default: next_s.state = dlo_pkg::S_GFX;
          endcase
        end
      end
      dlo_pkg::S_GFX: begin
        want = 1'b1;
        faddr = s.fptr;
        if (got) begin
          next_s.sh = MEM_DATA;
          next_s.fptr = s.fptr + 24'h00_0001;
          next_s.sh_cnt = (s.mode == dlo_pkg::M_HR) ? dlo_pkg::HR_PER_BYTE : 4'h1;
          next_s.state = dlo_pkg::S_EMIT;
        end
      end
      dlo_pkg::S_TX_CHAR: begin
        want = 1'b1;
        faddr = s.fptr;
        if (got) begin
          next_s.fptr = s.fptr + 24'h00_0001;
          if (s.skip) begin
            next_s.skip = 1'b0;
          end else begin
            next_s.chr = MEM_DATA;
            next_s.state = dlo_pkg::S_TX_ATTR;
          end
        end
      end
      dlo_pkg::S_TX_ATTR: begin
        want = 1'b1;
        faddr = s.fptr;
        if (got) begin
          next_s.attr = MEM_DATA;
          next_s.fptr = s.fptr + 24'h00_0001;
          next_s.state = dlo_pkg::S_TX_FONT;
        end
      end
      dlo_pkg::S_TX_FONT: begin
        want = 1'b1;
        faddr = ({16'h0000, s.font} << dlo_pkg::FONT_SHIFT)
              + {13'h0000, s.chr, s.row};
        if (got) begin
          next_s.sh = MEM_DATA;
          next_s.sh_cnt = dlo_pkg::GLYPH_W;
          next_s.state = dlo_pkg::S_EMIT;
        end
      end
      dlo_pkg::S_EMIT: begin
        next_s.pix.valid = 1'b1;
        next_s.pix.transp = px[8];
        next_s.pix.index = px[7:0];
        next_s.sh_cnt = s.sh_cnt - 4'h1;
        if (s.mode == dlo_pkg::M_HR) begin
          next_s.sh = {s.sh[3:0], 4'h0};
        end else begin
          next_s.sh = {s.sh[6:0], 1'b0};
        end
        if (s.mode != dlo_pkg::M_TEXT) begin
          next_s.items = s.items - 10'h001;
          last = (s.items == 10'h001);
        end else if (s.sh_cnt == 4'h1) begin
          next_s.items = s.items - 10'h001;
          last = (s.items == 10'h001);
        end
        if (last) begin
          next_s.state = dlo_pkg::S_LINE_END;
        end else if (s.sh_cnt == 4'h1) begin
          next_s.state = (s.mode == dlo_pkg::M_TEXT) ? dlo_pkg::S_TX_CHAR : dlo_pkg::S_GFX;
        end
      end
      dlo_pkg::S_LINE_END: begin
        next_s.pix.line_done = 1'b1;
        if (s.mode == dlo_pkg::M_TEXT) begin
          // Text rows advance once per glyph height
          next_s.row = s.row + 3'h1;
          if (s.row == dlo_pkg::GLYPH_LAST_ROW) begin
            next_s.scr_base = s.scr_base + {12'h000, s.step};
          end
        end else if (s.mode != dlo_pkg::M_OFF) begin
          next_s.scr_base = s.scr_base + {12'h000, s.step};
        end
        if (s.line_left != 8'h00) begin
          next_s.line_left = s.line_left - 8'h01;
          next_s.state = dlo_pkg::S_WAIT_LINE;
        end else if (s.cw[dlo_pkg::CW_END]) begin
          next_s.state = dlo_pkg::S_WAIT_VS;
        end else begin
          next_s.state = dlo_pkg::S_CW_LO;
        end
      end
      default: next_s.state = dlo_pkg::S_WAIT_VS;
    endcase

    // Memory handshake: request stands until acknowledged
    if (got) begin
      next_s.mem.req = 1'b0;
    end else if (want && !s.mem.req) begin
      next_s.mem.req = 1'b1;
      next_s.mem.addr = faddr;
    end

    // Disable abandons the frame, including any pending fetch
    if (!s.en) begin
      next_s.state = dlo_pkg::S_WAIT_VS;
      next_s.mem.req = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      s <= '0;
      s.state <= dlo_pkg::S_WAIT_VS;
      s.mode <= dlo_pkg::M_OFF;
      s.list_base <= dlo_pkg::LIST_BASE_RST;
      s.width <= dlo_pkg::WIDTH_NORMAL;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign MEM_REQ = s.mem.req;
  assign MEM_ADDR = s.mem.addr;
  assign PIX_VALID = s.pix.valid;
  assign PIX_INDEX = s.pix.index;
  assign PIX_TRANSP = s.pix.transp;
  assign LINE_DONE = s.pix.line_done;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_hr_left_nibble: assert property (
    (s.state == dlo_pkg::S_EMIT && s.mode == dlo_pkg::M_HR && s.sh_cnt == 4'h2)
    |=> (PIX_INDEX == {4'h0, $past(s.sh[7:4])})
    ##1 (PIX_INDEX == {4'h0, $past(s.sh[3:0], 2)} || !PIX_VALID))
    else $error("hires left pixel not from upper nibble");

  a_sr_zero_transp: assert property (
    (PIX_VALID && s.mode inside {dlo_pkg::M_SR, dlo_pkg::M_LR} && PIX_INDEX == 8'h00
     && $stable(s.no_trans))
    |-> (PIX_TRANSP == !s.no_trans))
    else $error("zero byte transparency wrong");

  a_text_solid_bg: assert property (
    (PIX_VALID && s.mode == dlo_pkg::M_TEXT && s.attr[7]) |-> !PIX_TRANSP)
    else $error("opaque text background shown transparent");

  a_text_plain_bg: assert property (
    (PIX_VALID && s.mode == dlo_pkg::M_TEXT && !s.attr[7] && PIX_INDEX[7])
    |-> (PIX_INDEX == dlo_pkg::TXT_BG_SOLID && PIX_TRANSP == !$past(s.no_trans)))
    else $error("plain text background colour wrong");

  a_end_waits_vs: assert property (
    (s.state == dlo_pkg::S_LINE_END && s.line_left == 8'h00 && s.cw[dlo_pkg::CW_END]
     && s.en) |=> (s.state == dlo_pkg::S_WAIT_VS) [*2])
    else $error("end record did not wait for vsync");

  a_extra_limit: assert property (
    s.extra <= dlo_pkg::MAX_EXTRA)
    else $error("more than twenty extra bytes fetched");

  a_step_add: assert property (
    (s.state == dlo_pkg::S_LINE_END && s.mode inside {dlo_pkg::M_SR, dlo_pkg::M_HR,
     dlo_pkg::M_LR}) |=> (s.scr_base == $past(s.scr_base) + {12'h000, $past(s.step)}))
    else $error("screen address not advanced by step");

  a_text_mode_sel: assert property (
    (s.state == dlo_pkg::S_OPT && s.grp == dlo_pkg::GRP_DONE && s.en
     && s.cw[dlo_pkg::CW_TXT_ON] && !s.cw[dlo_pkg::CW_OVL_OFF])
    |=> (s.mode == ($past(s.cw[dlo_pkg::CW_GFX_ON]) ? dlo_pkg::M_OFF : dlo_pkg::M_TEXT)))
    else $error("text mode selection wrong");

  a_repeat_load: assert property (
    (s.state == dlo_pkg::S_OPT && s.grp == dlo_pkg::GRP_DONE && s.en)
    |=> (s.line_left == $past(s.rpt)) && s.state == dlo_pkg::S_WAIT_LINE)
    else $error("repeat count not loaded");

  a_char_then_attr: assert property (
    (s.state == dlo_pkg::S_TX_CHAR && MEM_REQ && MEM_ACK && !s.skip && s.en)
    |=> s.state == dlo_pkg::S_TX_ATTR ##[1:1000] s.state == dlo_pkg::S_TX_FONT)
    else $error("char byte not followed by attribute");

  c_hires_pixel: cover property (PIX_VALID && s.mode == dlo_pkg::M_HR);
  c_text_line: cover property (LINE_DONE && s.mode == dlo_pkg::M_TEXT);
  c_list_end: cover property (s.state == dlo_pkg::S_LINE_END ##1 s.state == dlo_pkg::S_WAIT_VS);
  c_scroll_skip: cover property (s.state == dlo_pkg::S_TX_CHAR && s.skip && MEM_ACK);

endmodule

// file: rtl/dlo_pkg.sv
package dlo_pkg;

  // ---------------------------------------------------------------
  // Widths and APB map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LIST = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_NO_TRANS_BIT = 2;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_LINES_LSB = 8;
  localparam logic [23:0] LIST_BASE_RST = 24'h00_0000;

  // ---------------------------------------------------------------
  // Control word bits
  // ---------------------------------------------------------------
  localparam int CW_GFX_ON = 0;
  localparam int CW_OVL_OFF = 1;
  localparam int CW_TXT_ON = 2;
  localparam int CW_GRP0 = 4;
  localparam int CW_HIRES = 12;
  localparam int CW_LORES = 13;
  localparam int CW_END = 15;

  // Optional data groups in fetch order, byte count of each
  localparam int NUM_GRP = 7;
  localparam logic [2:0] GRP_LEN [0:6] = '{3'h1, 3'h5, 3'h2, 3'h1, 3'h5, 3'h4, 3'h2};
  localparam logic [2:0] GRP_RPT = 3'h0;
  localparam logic [2:0] GRP_OVADR = 3'h1;
  localparam logic [2:0] GRP_SCRL = 3'h2;
  localparam logic [2:0] GRP_FONT = 3'h3;
  localparam logic [2:0] GRP_ATT = 3'h6;
  localparam logic [2:0] GRP_DONE = 3'h7;
  localparam logic [4:0] MAX_EXTRA = 5'h14;

  // ---------------------------------------------------------------
  // Widths of a line per mode
  // ---------------------------------------------------------------
  localparam logic [1:0] WIDTH_NORMAL = 2'h1;
  localparam logic [9:0] SR_PIX [0:2] = '{10'h100, 10'h140, 10'h150};
  localparam logic [9:0] LR_PIX [0:2] = '{10'h080, 10'h0A0, 10'h0A8};
  localparam logic [9:0] HR_PIX [0:2] = '{10'h200, 10'h280, 10'h2A0};
  localparam logic [9:0] TX_CHR [0:2] = '{10'h040, 10'h050, 10'h054};
  localparam int FONT_SHIFT = 11;
  localparam logic [2:0] GLYPH_LAST_ROW = 3'h7;
  localparam logic [3:0] GLYPH_W = 4'h8;
  localparam logic [3:0] HR_PER_BYTE = 4'h2;
  localparam logic [7:0] TXT_BG_SOLID = 8'h80;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_WAIT_VS, S_CW_LO, S_CW_HI, S_OPT, S_WAIT_LINE, S_GFX,
    S_TX_CHAR, S_TX_ATTR, S_TX_FONT, S_EMIT, S_LINE_END
  } dlo_state_t;

  typedef enum logic [2:0] {M_OFF, M_SR, M_HR, M_LR, M_TEXT} dlo_mode_t;

  typedef struct packed {
    logic valid;
    logic transp;
    logic [7:0] index;
    logic line_done;
  } dlo_pix_t;

  typedef struct packed {
    logic req;
    logic [23:0] addr;
  } dlo_mem_t;

  typedef struct packed {
    dlo_state_t state;
    dlo_mode_t mode;
    logic en;
    logic no_trans;
    logic [23:0] list_base;
    logic [23:0] list_ptr;
    logic [15:0] cw;
    logic [2:0] grp;
    logic [2:0] gbyte;
    logic [4:0] extra;
    logic [7:0] rpt;
    logic [7:0] line_left;
    logic [23:0] scr_base;
    logic [23:0] fptr;
    logic [11:0] step;
    logic [7:0] hscroll;
    logic [7:0] font;
    logic [1:0] width;
    logic [9:0] items;
    logic [7:0] chr;
    logic [7:0] attr;
    logic [7:0] sh;
    logic [3:0] sh_cnt;
    logic [2:0] row;
    logic skip;
    dlo_pix_t pix;
    dlo_mem_t mem;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic vs_m;
    logic vs_s;
    logic vs_d;
    logic ls_m;
    logic ls_s;
    logic ls_d;
  } dlo_st_t;

endpackage

// file: verification/dlo_vmem_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Video memory seen from the fetch port
// ---------------------------------------------------------------
module dlo_vmem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic slow,
  input wire logic [23:0] addr,
  output logic ack,
  output logic [7:0] data
);
  logic [7:0] mem [0:4095];
  logic [1:0] wt;

  // Data line toggles when idle, so a stale byte never reads as valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      wt <= 2'h0;
      data <= 8'h00;
    end else if (req && !ack && wt >= {slow, slow}) begin
      ack <= 1'b1;
      data <= mem[addr[11:0]];
      wt <= 2'h0;
    end else begin
      ack <= 1'b0;
      data <= ~data;
      wt <= (req && !ack) ? wt + 2'h1 : 2'h0;
    end
  end
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps

module testbench;
  typedef struct {logic [15:0] cw; logic [31:0] ctrl; int cnt; logic [7:0] v; logic t0;} dlo_row_t;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, vs = 0, ls = 0, slow = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, rerr, mreq, mack, pv, ptr, ldone;
  logic [23:0] maddr;
  logic [7:0] mdata, pidx;
  logic [7:0] pix [0:1023];
  logic trn [0:1023];
  int n = 0, err_count = 0, checks = 0, cyc = 0;
  dlo_row_t rows [0:6] = '{
    '{16'h8031, 32'h0000_0001, 320, 8'h25, 1'b1},
    '{16'h8031, 32'h0000_0005, 320, 8'h25, 1'b0},
    '{16'h9031, 32'h0000_0001, 640, 8'h02, 1'b1},
    '{16'hA031, 32'h0000_0001, 160, 8'h25, 1'b1},
    '{16'hB031, 32'h0000_0001, 0, 8'h00, 1'b0},
    '{16'h8035, 32'h0000_0001, 0, 8'h00, 1'b0},
    '{16'h80F4, 32'h0000_0001, 640, 8'h80, 1'b1}};

  always #20 clk = ~clk;

  dlo_overlay_renderer i_dut (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .VSYNC(vs), .LINE_START(ls), .MEM_REQ(mreq), .MEM_ADDR(maddr),
    .MEM_ACK(mack), .MEM_DATA(mdata), .PIX_VALID(pv), .PIX_INDEX(pidx),
    .PIX_TRANSP(ptr), .LINE_DONE(ldone));
  dlo_vmem_model i_mem (.clk(clk), .rst(rst), .req(mreq), .slow(slow), .addr(maddr),
    .ack(mack), .data(mdata));

  // ---------------------------------------------------------------
  // Pixel capture and hang guard
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Count restarts while the line start strobe stands
    if (ls === 1'b1) begin
      n <= 0;
    end else if (pv === 1'b1) begin
      pix[n] <= pidx;
      trn[n] <= ptr;
      n <= n + 1;
    end
    if (cyc == 60000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until PREADY is seen high at an edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // List author sends at most nine extra bytes, under twenty
  // Scroll of one and font base one follow; fetched only when flagged
  task automatic put_list(logic [15:0] cw, logic [7:0] rpt);
    logic [7:0] b [0:10];
    b = '{cw[7:0], cw[15:8], rpt, 8'h00, 8'h01, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01};
    foreach (b[k]) i_mem.mem[k] = b[k];
  endtask

  task automatic frame();
    vs <= 1'b1;
    repeat (4) @(posedge clk);
    vs <= 1'b0;
    repeat (100) @(posedge clk);
  endtask

  // A line slot that never ends is a result of its own, not a hang
  task automatic line(int want, logic done_exp);
    int t;
    t = 0;
    ls <= 1'b1;
    repeat (4) @(posedge clk);
    ls <= 1'b0;
    do @(posedge clk); while (ldone !== 1'b1 && ++t < 3000);
    @(posedge clk);
    chk("line done", done_exp, t < 3000);
    chk("pixel count", want, n);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    for (int a = 0; a < 4096; a++) i_mem.mem[a] = a[7:0];
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk("outputs at reset", 0, {pready, pslverr, mreq, pv, ldone});
    apb(1'b0, dlo_pkg::OFS_CTRL, 32'h0000_0000);
    chk("ctrl reset", 0, rd);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("unmapped error", 1, rerr);
    foreach (rows[i]) begin
      slow <= i[0];
      put_list(rows[i].cw, 8'h00);
      apb(1'b1, dlo_pkg::OFS_CTRL, rows[i].ctrl);
      frame();
      line(rows[i].cnt, 1'b1);
      if (rows[i].cnt != 0) begin
        chk("pixel 37", rows[i].v, pix[37]);
        chk("pixel 0 transp", rows[i].t0, trn[0]);
      end
      $display("row %0d done", i);
    end
    chk("text fg pixel 4", 8'h02, pix[4]);
    chk("text fg transp", 0, trn[4]);
    chk("text solid bg 509", 8'h80, pix[509]);
    chk("text solid bg transp", 0, trn[509]);
    apb(1'b0, dlo_pkg::OFS_CTRL, 32'h0000_0000);
    chk("ctrl readback", 1, rd);
    put_list(16'h8031, 8'h01);
    frame();
    line(320, 1'b1);
    line(320, 1'b1);
    chk("second line pixel 0", 8'h10, pix[0]);
    line(0, 1'b0);
    frame();
    line(320, 1'b1);
    chk("restart pixel 5", 8'h05, pix[5]);
    $display("repeat and restart done");
    final_report();
  end
endmodule
